// ### logic/uab_regs.svh
// register offsets, field positions, reset values and counts of the autobaud/wake/break block
`ifndef UAB_REGS_SVH
`define UAB_REGS_SVH
`define UAB_OFF_CTRL 8'h00
`define UAB_OFF_STAT 8'h04
`define UAB_OFF_DIVL 8'h08
`define UAB_OFF_DIVH 8'h0C
`define UAB_OFF_RXD 8'h10
`define UAB_OFF_TXD 8'h14
`define UAB_CTRL_ABD 0
`define UAB_CTRL_WUE 1
`define UAB_CTRL_WIDE 2
`define UAB_CTRL_HS 3
`define UAB_CTRL_SB 4
`define UAB_CTRL_TRANSMIT_ENABLE 5
`define UAB_CTRL_OVF 6
`define UAB_STAT_RXF 0
`define UAB_STAT_IDLE 1
`define UAB_STAT_TEMPTY 2
`define UAB_STAT_TFULL 3
`define UAB_RESP_OK 2'h0
`define UAB_RESP_ERR 2'h2
`define UAB_PRESC_SLOW 24'h000040
`define UAB_PRESC_MID 24'h000010
`define UAB_PRESC_FAST 24'h000004
`define UAB_ABD_DIV 24'h000008
`define UAB_DIV_RST 16'h0000
`define UAB_DIV_MAX 16'hFFFF
`define UAB_ABD_START 16'h0001
`define UAB_FIFTH_EDGE 3'h4
`define UAB_BRK_BITS 4'hE
`define UAB_CHAR_BITS 4'hA
`define UAB_RX_LAST 4'h7
`endif

// ### logic/uab_pkg.sv
// types of the autobaud/wake/break block
package uab_pkg;
  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } uab_axi_req_t;
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } uab_axi_rsp_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP, AB_START, AB_COUNT, WK_FALL, WK_RISE} uab_rx_t;
  typedef enum logic {TX_IDLE, TX_SHIFT} uab_tx_t;
  typedef struct packed {
    uab_axi_rsp_t axi;
    logic aw_got;
    logic [7:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic autobaud_enable;
    logic wake_on_break_enable;
    logic wide_divider_select;
    logic high_speed_select;
    logic send_break;
    logic transmit_enable;
    logic autobaud_overflow_flag;
    logic [15:0] div;
    logic [7:0] receive_data_reg;
    logic receive_flag;
    logic receive_idle;
    uab_rx_t rx_st;
    logic [7:0] rx_sh;
    logic [3:0] rx_cnt;
    logic [23:0] rx_tmr;
    logic rx_sync1;
    logic rx_sync2;
    logic rx_prev;
    logic [9:0] abd_pre;
    logic [2:0] edges;
    uab_tx_t tx_st;
    logic [13:0] tx_sh;
    logic [3:0] tx_cnt;
    logic [23:0] tx_tmr;
    logic [7:0] tx_buf;
    logic tx_full;
    logic tx_brk;
    logic transmit_shift_empty;
    logic tx_line;
  } uab_state_t;
endpackage : uab_pkg

// ### logic/uab_top.sv
// serial port helper: autobaud calibration, wake on break, break transmit, AXI4-Lite registers
//
// The register addresses and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ps
`include "uab_regs.svh"
module uab_top
  import uab_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire uab_axi_req_t i_axi,
  output uab_axi_rsp_t o_axi,
  input wire logic i_receive_line,
  output logic o_transmit_line,
  output logic o_receive_flag
);
  uab_state_t s_reg;
  uab_state_t s_next;
  logic [23:0] presc;
  logic [15:0] div_eff;
  logic [23:0] bit_period;
  logic [23:0] abd_limit;
  logic rise;
  logic fall;
  logic line;
  logic abd_tick;
  logic rx_due;
  logic tx_due;
  logic wr_go;
  logic rd_rxd;
  logic div_wr;
  logic lane0;

  // edges of the synchronised receive line
  assign line = s_reg.rx_sync2;
  assign rise = s_reg.rx_sync2 && !s_reg.rx_prev;
  assign fall = !s_reg.rx_sync2 && s_reg.rx_prev;
  assign rx_due = (s_reg.rx_tmr == 24'h000000);
  assign tx_due = (s_reg.tx_tmr == 24'h000000);

  // base prescale and bit period from the select bits and divisor
  always_comb
  begin
    case ({s_reg.wide_divider_select, s_reg.high_speed_select})
      2'b00: presc = `UAB_PRESC_SLOW;
      2'b11: presc = `UAB_PRESC_FAST;
      default: presc = `UAB_PRESC_MID;
    endcase
    div_eff = s_reg.wide_divider_select ? s_reg.div : {8'h00, s_reg.div[7:0]};
    bit_period = 24'(presc * {8'h00, div_eff}) + presc;
    abd_limit = 24'(presc * `UAB_ABD_DIV);
  end
  assign abd_tick = ({14'h0000, s_reg.abd_pre} == abd_limit - 24'h000001);

  // next state of the whole block
  always_comb
  begin
    s_next = s_reg;
    wr_go = 1'b0;
    rd_rxd = 1'b0;
    div_wr = 1'b0;
    lane0 = 1'b0;
    s_next.rx_sync1 = i_receive_line;
    s_next.rx_sync2 = s_reg.rx_sync1;
    s_next.rx_prev = s_reg.rx_sync2;
    s_next.rx_tmr = rx_due ? 24'h000000 : s_reg.rx_tmr - 24'h000001;
    s_next.tx_tmr = tx_due ? 24'h000000 : s_reg.tx_tmr - 24'h000001;
    // write address and data taken in either order
    if (i_axi.awvalid && s_reg.axi.awready)
    begin
      s_next.aw_got = 1'b1;
      s_next.awaddr = i_axi.awaddr;
    end
    if (i_axi.wvalid && s_reg.axi.wready)
    begin
      s_next.w_got = 1'b1;
      s_next.wdata = i_axi.wdata;
      s_next.wstrb = i_axi.wstrb;
    end
    if (i_axi.bready && s_reg.axi.bvalid)
      s_next.axi.bvalid = 1'b0;
    wr_go = s_next.aw_got && s_next.w_got && !s_next.axi.bvalid;
    lane0 = s_next.wstrb[0];
    // register write decode
    if (wr_go)
    begin
      s_next.aw_got = 1'b0;
      s_next.w_got = 1'b0;
      s_next.axi.bvalid = 1'b1;
      s_next.axi.bresp = `UAB_RESP_OK;
      case (s_next.awaddr)
        `UAB_OFF_CTRL:
          if (lane0)
          begin
            s_next.autobaud_enable = s_next.wdata[`UAB_CTRL_ABD];
            s_next.wake_on_break_enable = s_next.wdata[`UAB_CTRL_WUE];
            s_next.wide_divider_select = s_next.wdata[`UAB_CTRL_WIDE];
            s_next.high_speed_select = s_next.wdata[`UAB_CTRL_HS];
            s_next.send_break = s_next.wdata[`UAB_CTRL_SB];
            s_next.transmit_enable = s_next.wdata[`UAB_CTRL_TRANSMIT_ENABLE];
            if (!s_next.wdata[`UAB_CTRL_OVF])
              s_next.autobaud_overflow_flag = 1'b0; // write 0 clears
          end
        `UAB_OFF_DIVL:
          if (lane0)
          begin
            s_next.div[7:0] = s_next.wdata[7:0];
            div_wr = 1'b1;
          end
        `UAB_OFF_DIVH:
          if (lane0)
          begin
            s_next.div[15:8] = s_next.wdata[7:0];
            div_wr = 1'b1;
          end
        // write launches a character or break
        `UAB_OFF_TXD:
          if (lane0 && s_reg.transmit_enable && !s_reg.tx_full)
          begin
            s_next.tx_full = 1'b1;
            s_next.tx_buf = s_next.wdata[7:0];
          end
        `UAB_OFF_STAT, `UAB_OFF_RXD: s_next.axi.bresp = `UAB_RESP_OK;
        default: s_next.axi.bresp = `UAB_RESP_ERR;
      endcase
    end
    // register read decode
    if (i_axi.rready && s_reg.axi.rvalid)
      s_next.axi.rvalid = 1'b0;
    if (i_axi.arvalid && s_reg.axi.arready)
    begin
      s_next.axi.rvalid = 1'b1;
      s_next.axi.rresp = `UAB_RESP_OK;
      s_next.axi.rdata = 32'h00000000;
      case (i_axi.araddr)
        `UAB_OFF_CTRL: s_next.axi.rdata[6:0] = {s_reg.autobaud_overflow_flag, s_reg.transmit_enable,
          s_reg.send_break, s_reg.high_speed_select, s_reg.wide_divider_select,
          s_reg.wake_on_break_enable, s_reg.autobaud_enable};
        `UAB_OFF_STAT: s_next.axi.rdata[3:0] = {s_reg.tx_full, s_reg.transmit_shift_empty,
          s_reg.receive_idle, s_reg.receive_flag};
        `UAB_OFF_DIVL: s_next.axi.rdata[7:0] = s_reg.div[7:0];
        `UAB_OFF_DIVH: s_next.axi.rdata[7:0] = s_reg.div[15:8];
        `UAB_OFF_RXD:
        begin
          s_next.axi.rdata[7:0] = s_reg.receive_data_reg;
          rd_rxd = 1'b1;
        end
        `UAB_OFF_TXD: s_next.axi.rdata = 32'h00000000;
        default: s_next.axi.rresp = `UAB_RESP_ERR;
      endcase
    end
    // data read clears flag, later sets win
    if (rd_rxd)
      s_next.receive_flag = 1'b0;
    // receive side: normal reception, calibration, wake watch
    case (s_reg.rx_st)
      RX_IDLE:
        if (s_reg.wake_on_break_enable)
          s_next.rx_st = WK_FALL;
        else if (s_reg.autobaud_enable)
          s_next.rx_st = AB_START;
        else if (fall)
        begin
          s_next.rx_st = RX_START;
          s_next.rx_tmr = bit_period >> 1;
        end
      RX_START:
        if (rx_due)
        begin
          s_next.rx_st = line ? RX_IDLE : RX_DATA;
          s_next.rx_tmr = bit_period - 24'h000001;
          s_next.rx_cnt = 4'h0;
        end
      RX_DATA:
        if (rx_due)
        begin
          s_next.rx_sh = {line, s_reg.rx_sh[7:1]};
          s_next.rx_tmr = bit_period - 24'h000001;
          s_next.rx_cnt = s_reg.rx_cnt + 4'h1;
          if (s_reg.rx_cnt == `UAB_RX_LAST)
            s_next.rx_st = RX_STOP;
        end
      RX_STOP:
        if (rx_due)
        begin
          s_next.receive_data_reg = s_reg.rx_sh;
          s_next.receive_flag = 1'b1;
          s_next.rx_st = RX_IDLE;
        end
      AB_START:
        if (!s_reg.autobaud_enable)
          s_next.rx_st = RX_IDLE;
        else if (rise)
        begin
          s_next.rx_st = AB_COUNT;
          s_next.div = `UAB_ABD_START;
          s_next.edges = 3'h1;
          s_next.abd_pre = 10'h000;
        end
      AB_COUNT:
        if (!s_reg.autobaud_enable)
          s_next.rx_st = RX_IDLE;
        else
        begin
          s_next.abd_pre = abd_tick ? 10'h000 : s_reg.abd_pre + 10'h001;
          if (abd_tick)
          begin
            s_next.div = s_reg.div + 16'h0001;
            if (s_reg.div == `UAB_DIV_MAX)
            begin
              s_next.autobaud_overflow_flag = 1'b1;
              s_next.receive_flag = 1'b1;
            end
          end
          if (rise)
          begin
            if (s_reg.edges == `UAB_FIFTH_EDGE)
            begin
              s_next.autobaud_enable = 1'b0;
              s_next.receive_flag = 1'b1;
              s_next.rx_st = RX_IDLE;
            end
            else
              s_next.edges = s_reg.edges + 3'h1;
          end
        end
      WK_FALL:
        if (!s_reg.wake_on_break_enable)
          s_next.rx_st = RX_IDLE;
        // falling edge is the wake event
        else if (fall)
        begin
          s_next.receive_flag = 1'b1;
          s_next.rx_st = WK_RISE;
        end
      WK_RISE:
        // rest of character is a fragment
        if (rise || !s_reg.wake_on_break_enable)
        begin
          s_next.wake_on_break_enable = 1'b0;
          s_next.rx_st = RX_IDLE;
        end
      default: s_next.rx_st = RX_IDLE;
    endcase
    s_next.receive_idle = (s_next.rx_st == RX_IDLE) || (s_next.rx_st == WK_FALL);
    // transmit side: characters and breaks
    case (s_reg.tx_st)
      TX_IDLE:
        if (s_reg.tx_full && s_reg.transmit_enable)
        begin
          s_next.tx_full = 1'b0;
          s_next.tx_st = TX_SHIFT;
          s_next.tx_tmr = bit_period - 24'h000001;
          s_next.tx_line = 1'b0;
          if (s_reg.send_break)
          begin
            s_next.tx_sh = 14'h2000;
            s_next.tx_cnt = `UAB_BRK_BITS;
            s_next.tx_brk = 1'b1;
          end
          else
          begin
            s_next.tx_sh = {4'hF, 1'b1, s_reg.tx_buf, 1'b0};
            s_next.tx_cnt = `UAB_CHAR_BITS;
            s_next.tx_brk = 1'b0;
          end
        end
      TX_SHIFT:
        if (tx_due)
        begin
          s_next.tx_tmr = bit_period - 24'h000001;
          if (s_reg.tx_cnt == 4'h1)
          begin
            s_next.tx_st = TX_IDLE;
            s_next.tx_line = 1'b1;
            if (s_reg.tx_brk)
              s_next.send_break = 1'b0;
          end
          else
          begin
            s_next.tx_sh = s_reg.tx_sh >> 1;
            s_next.tx_line = s_reg.tx_sh[1];
            s_next.tx_cnt = s_reg.tx_cnt - 4'h1;
          end
        end
      default: s_next.tx_st = TX_IDLE;
    endcase
    s_next.transmit_shift_empty = (s_next.tx_st == TX_IDLE);
    if (div_wr)
    begin
      s_next.rx_tmr = 24'h000000;
      s_next.tx_tmr = 24'h000000;
    end
    // bus ready flags for the next cycle
    s_next.axi.awready = !s_next.aw_got && !s_next.axi.bvalid;
    s_next.axi.wready = !s_next.w_got && !s_next.axi.bvalid;
    s_next.axi.arready = !s_next.axi.rvalid;
  end

  // state register
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      s_reg <= '0;
      s_reg.rx_sync1 <= 1'b1;
      s_reg.rx_sync2 <= 1'b1;
      s_reg.rx_prev <= 1'b1;
      s_reg.tx_line <= 1'b1;
      s_reg.receive_idle <= 1'b1;
      s_reg.transmit_shift_empty <= 1'b1;
      s_reg.div <= `UAB_DIV_RST;
    end
    else
      s_reg <= s_next;
  end

  // outputs straight from the state register
  assign o_axi = s_reg.axi;
  assign o_transmit_line = s_reg.tx_line;
  assign o_receive_flag = s_reg.receive_flag;

  // checks on calibration, wake, break, shift-empty and data-read behaviour
  a_abd_idle_hold:
    assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (s_reg.rx_st == AB_COUNT) |-> !s_reg.receive_idle)
    else $error("receive idle high during calibration");
  a_abd_count_one:
    assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (s_reg.rx_st == AB_START && s_reg.autobaud_enable && rise) |=> (s_reg.div == 16'h0001 && s_reg.edges == 3'h1))
    else $error("calibration count did not start at one");
  a_abd_count_up:
    assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (s_reg.rx_st == AB_COUNT && s_reg.autobaud_enable && abd_tick) |=> (s_reg.div == $past(s_reg.div) + 16'h0001))
    else $error("calibration counter did not advance on its tick");
  a_abd_tick_rate:
    assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (s_reg.rx_st == AB_COUNT) |-> ({14'h0000, s_reg.abd_pre} < abd_limit))
    else $error("calibration prescaler exceeded its period");
  a_abd_fifth_end:
    assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (s_reg.rx_st == AB_COUNT && s_reg.autobaud_enable && rise && s_reg.edges == 3'h4)
      |=> (!s_reg.autobaud_enable && s_reg.receive_flag && s_reg.receive_idle))
    else $error("fifth rise did not end calibration");
  a_abd_overflow_set:
    assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (s_reg.rx_st == AB_COUNT && s_reg.autobaud_enable && abd_tick && s_reg.div == 16'hFFFF)
      |=> (s_reg.autobaud_overflow_flag && s_reg.receive_flag && s_reg.div == 16'h0000))
    else $error("overflow not flagged");
  a_wake_flag_set:
    assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (s_reg.rx_st == WK_FALL && s_reg.wake_on_break_enable && fall) |=> s_reg.receive_flag ##1 (s_reg.rx_st != RX_DATA))
    else $error("wake event did not set receive flag");
  a_wake_enable_clr:
    assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (s_reg.rx_st == WK_RISE && rise) |=> (!s_reg.wake_on_break_enable && s_reg.rx_st == RX_IDLE))
    else $error("wake enable not cleared at end of break");
  a_break_frame_len:
    assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (s_reg.tx_st == TX_IDLE && s_reg.tx_full && s_reg.transmit_enable && s_reg.send_break)
      |=> (s_reg.tx_cnt == 4'hE && !s_reg.tx_line && s_reg.tx_sh == 14'h2000))
    else $error("break frame not fourteen bits of zero and stop");
  a_break_sb_clear:
    assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (s_reg.tx_st == TX_SHIFT && s_reg.tx_brk && tx_due && s_reg.tx_cnt == 4'h1)
      |=> (!s_reg.send_break && s_reg.tx_line && s_reg.transmit_shift_empty))
    else $error("send break not cleared after stop bit");
  a_tsr_busy_flag:
    assert property (@(posedge i_ref_clk) disable iff (i_rst)
      $rose(s_reg.tx_st == TX_SHIFT) |-> !s_reg.transmit_shift_empty)
    else $error("shift empty high while sending");
  a_rxd_read_clr:
    assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (rd_rxd && s_reg.rx_st == RX_IDLE && !s_reg.wake_on_break_enable && !s_reg.autobaud_enable && !fall)
      |=> !s_reg.receive_flag)
    else $error("receive data read did not clear flag");
endmodule : uab_top

// ### verif/uab_node.sv
// remote serial node: drives the receive line and times low runs on the transmit line
`timescale 1ns/1ps
module uab_node (
  input wire logic i_ref_clk,
  input wire logic i_transmit_line,
  output logic o_receive_line
);
  int low_cnt;
  int runs[$];
  // line is driven high from the start, so it idles high
  initial
  begin
    o_receive_line = 1'b1;
    low_cnt = 0;
  end
  // length in cycles of each completed low run on the transmit line
  always @(posedge i_ref_clk)
  begin
    if (i_transmit_line === 1'b0)
      low_cnt <= low_cnt + 1;
    else if (low_cnt != 0)
    begin
      runs.push_back(low_cnt);
      low_cnt <= 0;
    end
  end
  // hold one level for a number of cycles, changing just after an edge
  task automatic hold_bit(input logic v, input int per);
    begin
      @(posedge i_ref_clk);
      o_receive_line <= v;
      repeat (per - 1) @(posedge i_ref_clk);
    end
  endtask : hold_bit
  // one 8N1 character, least significant bit first
  task automatic send_byte(input logic [7:0] c, input int per);
    logic [9:0] f;
    begin
      f = {1'b1, c, 1'b0};
      for (int i = 0; i < 10; i++)
        hold_bit(f[i], per);
    end
  endtask : send_byte
endmodule : uab_node

// ### verif/uab_top_tb.sv
// self-checking bench: registers, break transmit, wake and autobaud calibration
`timescale 1ns/1ps
`include "uab_regs.svh"
module uab_top_tb
  import uab_pkg::*;
;
  logic i_ref_clk = 1'b0;
  logic i_rst = 1'b1;
  uab_axi_req_t req = '0;
  uab_axi_rsp_t rsp;
  logic tx_line;
  logic rx_line;
  logic rx_flag;
  int bad_count = 0;
  int n_tests = 0;
  logic [31:0] seed = 32'h19E6023E;
  logic [31:0] d;
  logic [1:0] r;
  int per;
  int exp_div;
  uab_top i_uab_top (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_axi(req), .o_axi(rsp),
    .i_receive_line(rx_line), .o_transmit_line(tx_line), .o_receive_flag(rx_flag));
  uab_node i_uab_node (.i_ref_clk(i_ref_clk), .i_transmit_line(tx_line), .o_receive_line(rx_line));
  // 100 MHz clock
  always #5 i_ref_clk = ~i_ref_clk;
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      t = t ^ (t << 5);
      return t;
    end
  endfunction : xs
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    begin
      n_tests++;
      if (got !== exp)
      begin
        bad_count++;
        $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask : chk
  task automatic close_out();
    begin
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask : close_out
  // write: address and data offered together, each released when taken
  task automatic axw(input logic [7:0] a, input logic [31:0] v);
    logic done;
    begin
      done = 1'b0;
      @(posedge i_ref_clk);
      req.awaddr <= a;
      req.awvalid <= 1'b1;
      req.wdata <= v;
      req.wstrb <= 4'hF;
      req.wvalid <= 1'b1;
      req.bready <= 1'b1;
      for (int n = 0; n < 40 && !done; n++)
      begin
        @(posedge i_ref_clk);
        if (req.awvalid && rsp.awready)
          req.awvalid <= 1'b0;
        if (req.wvalid && rsp.wready)
          req.wvalid <= 1'b0;
        if (rsp.bvalid)
        begin
          req.bready <= 1'b0;
          done = 1'b1;
        end
      end
      if (!done)
      begin
        chk(32'h0, 32'h1);
        close_out();
      end
    end
  endtask : axw
  // read: data and response taken at the edge where rvalid is seen
  task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    logic done;
    begin
      done = 1'b0;
      v = '0;
      rs = '0;
      @(posedge i_ref_clk);
      req.araddr <= a;
      req.arvalid <= 1'b1;
      req.rready <= 1'b1;
      for (int n = 0; n < 40 && !done; n++)
      begin
        @(posedge i_ref_clk);
        if (req.arvalid && rsp.arready)
          req.arvalid <= 1'b0;
        if (rsp.rvalid)
        begin
          v = rsp.rdata;
          rs = rsp.rresp;
          req.rready <= 1'b0;
          done = 1'b1;
        end
      end
      if (!done)
      begin
        chk(32'h0, 32'h1);
        close_out();
      end
    end
  endtask : axr
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    logic [1:0] rs;
    begin
      axr(a, v, rs);
      chk(v, e);
      chk({30'h0, rs}, {30'h0, `UAB_RESP_OK});
    end
  endtask : rdchk
  // hang guard
  initial
  begin
    repeat (100000) @(posedge i_ref_clk);
    chk(32'h0, 32'h1);
    close_out();
  end
  initial
  begin
    repeat (5) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    // reset values and an unmapped place
    rdchk(`UAB_OFF_STAT, 32'h6);
    rdchk(`UAB_OFF_CTRL, 32'h0);
    axr(8'h1C, d, r);
    chk({30'h0, r}, {30'h0, `UAB_RESP_ERR});
    // break with a random ignored value, then a preloaded byte; 64 cycles a bit
    axw(`UAB_OFF_DIVL, 32'h0);
    axw(`UAB_OFF_CTRL, 32'h30);
    seed = xs(seed);
    i_uab_node.runs.delete();
    axw(`UAB_OFF_TXD, seed);
    axw(`UAB_OFF_TXD, 32'h55);
    rdchk(`UAB_OFF_CTRL, 32'h30);
    axr(`UAB_OFF_STAT, d, r);
    chk({31'h0, d[`UAB_STAT_TEMPTY]}, 32'h0);
    repeat (26 * 64) @(posedge i_ref_clk);
    rdchk(`UAB_OFF_CTRL, 32'h20);
    rdchk(`UAB_OFF_STAT, 32'h6);
    chk(i_uab_node.runs[0], 13 * 64);
    chk(i_uab_node.runs[1], 64);
    // wake on a long low with autobaud armed too
    axw(`UAB_OFF_CTRL, 32'h0B);
    i_uab_node.hold_bit(1'b0, 400);
    chk({31'h0, rx_flag}, 32'h1);
    rdchk(`UAB_OFF_CTRL, 32'h0B);
    i_uab_node.hold_bit(1'b0, 432);
    i_uab_node.hold_bit(1'b1, 100);
    rdchk(`UAB_OFF_CTRL, 32'h09);
    axr(`UAB_OFF_RXD, d, r);
    rdchk(`UAB_OFF_STAT, 32'h4);
    // sync character at a random rate; tick is 128 cycles, count starts at one
    seed = xs(seed);
    per = 1280 + int'(seed[7:0]);
    exp_div = 1 + per / 16;
    fork
      i_uab_node.send_byte(8'h55, per);
      begin
        repeat (4 * per) @(posedge i_ref_clk);
        rdchk(`UAB_OFF_STAT, 32'h4);
      end
    join
    chk({31'h0, rx_flag}, 32'h1);
    rdchk(`UAB_OFF_CTRL, 32'h08);
    axr(`UAB_OFF_DIVL, d, r);
    chk({31'h0, int'(d) >= exp_div - 1 && int'(d) <= exp_div + 1}, 32'h1);
    rdchk(`UAB_OFF_DIVH, 32'h0);
    rdchk(`UAB_OFF_STAT, 32'h7);
    axr(`UAB_OFF_RXD, d, r);
    rdchk(`UAB_OFF_STAT, 32'h6);
    // overflow: divisor high forced to FF mid-count, tick is 32 cycles, 1500 cycles a bit
    axw(`UAB_OFF_CTRL, 32'h0D);
    fork
      i_uab_node.send_byte(8'h55, 1500);
      begin
        repeat (2 * 1500) @(posedge i_ref_clk);
        d = 32'h0;
        // a write that meets a tick is lost to the counter, so try again
        for (int k = 0; k < 4 && d[7:0] != 8'hFF; k++)
        begin
          axw(`UAB_OFF_DIVH, 32'hFF);
          axr(`UAB_OFF_DIVH, d, r);
        end
        repeat (6 * 1500) @(posedge i_ref_clk);
        rdchk(`UAB_OFF_CTRL, 32'h4D);
        chk({31'h0, rx_flag}, 32'h1);
        axr(`UAB_OFF_RXD, d, r);
        rdchk(`UAB_OFF_STAT, 32'h4);
      end
    join
    chk({31'h0, rx_flag}, 32'h1);
    rdchk(`UAB_OFF_STAT, 32'h7);
    rdchk(`UAB_OFF_CTRL, 32'h4C);
    rdchk(`UAB_OFF_DIVH, 32'h0);
    axr(`UAB_OFF_RXD, d, r);
    axw(`UAB_OFF_CTRL, 32'h0C);
    rdchk(`UAB_OFF_CTRL, 32'h0C);
    // calibration cancelled after the first rise: later falls start characters
    axw(`UAB_OFF_CTRL, 32'h0D);
    fork
      i_uab_node.send_byte(8'h55, 600);
      begin
        repeat (900) @(posedge i_ref_clk);
        axw(`UAB_OFF_CTRL, 32'h0C);
      end
    join
    rdchk(`UAB_OFF_STAT, 32'h7);
    axr(`UAB_OFF_RXD, d, r);
    // non-zero character while waking: first low run wakes, rest is a fragment
    rdchk(`UAB_OFF_STAT, 32'h6);
    axw(`UAB_OFF_CTRL, 32'h0E);
    i_uab_node.send_byte(8'h55, 600);
    rdchk(`UAB_OFF_CTRL, 32'h0C);
    rdchk(`UAB_OFF_STAT, 32'h7);
    close_out();
  end
endmodule : uab_top_tb
